//--- common/pcs_consts.vh
// constants for the program counter and return stack block
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH
`define PCS_PC_W 13
`define PCS_LOW_W 8
`define PCS_HIGH_W 5
`define PCS_PAGE_MSB 4
`define PCS_PAGE_LSB 3
`define PCS_JUMP_W 11
`define PCS_STACK_DEPTH 8
`define PCS_PTR_W 3
`define PCS_PC_RESET 13'h0000
`define PCS_LATCH_RESET 5'h00
`define PCS_LOW_RESET 8'h00
`define PCS_HIGH_RESET 5'h00
`define PCS_VECTOR_DEFAULT 13'h0004
`endif

//--- design/pcs_return_stack.v
// eight-entry circular return stack
`timescale 1ns/10ps
`include "pcs_consts.vh"
module pcs_return_stack #(
    parameter DEPTH = `PCS_STACK_DEPTH,
    parameter PTR_W = `PCS_PTR_W,
    parameter WIDTH = `PCS_PC_W
) (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire push,
    input wire pop,
    input wire [WIDTH-1:0] push_data,
    output wire [WIDTH-1:0] top_data
);
    // storage is private: no address space reaches it
    reg [WIDTH-1:0] entry [0:DEPTH-1];
    // pointer names the next free slot; wraps silently, no overflow flag
    reg [PTR_W-1:0] ptr;
    wire [PTR_W-1:0] ptr_dec;
    assign ptr_dec = ptr - {{(PTR_W-1){1'b0}}, 1'b1};
    assign top_data = entry[ptr_dec];

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr <= {PTR_W{1'b0}};
        end else if (clk_en) begin
            if (push) begin
                ptr <= ptr + {{(PTR_W-1){1'b0}}, 1'b1};
            end else if (pop) begin
                ptr <= ptr_dec;
            end
        end
    end

    // data array has no reset; contents are meaningless until pushed
    always @(posedge core_clk) begin
        if (clk_en && push) begin
            entry[ptr] <= push_data;
        end
    end
endmodule // pcs_return_stack

//--- design/pcs_program_counter.v
// program counter, high-byte latch and page selection with return stack
`timescale 1ns/10ps
`include "pcs_consts.vh"
// Notes on behaviour
// - program counter is 13 bits; low byte readable and writable.
// - upper five bits unreadable; written only through the high latch.
// - every reset clears the upper counter bits.
// - writing the low byte loads upper bits from latch bits 4..0.
// - call or jump uses 11 instruction bits plus latch bits 4..3.
// - one 8K word space split into 2K pages by two page bits.
// - return stack is eight entries of full 13-bit counter.
// - stack lies outside memory spaces; pointer not software visible.
// - push counter on call and on interrupt vectoring.
// - the single return input pops and restores full 13-bit counter.
// - pushes and pops leave the high latch unchanged.
// - stack is circular; ninth push overwrites the oldest entry.
// - no overflow or underflow indication exists.
module pcs_program_counter #(
    parameter [`PCS_PC_W-1:0] INT_VECTOR = `PCS_VECTOR_DEFAULT,
    parameter STACK_DEPTH = `PCS_STACK_DEPTH,
    parameter STACK_PTR_W = `PCS_PTR_W
) (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire step,
    input wire low_write,
    input wire [`PCS_LOW_W-1:0] low_wdata,
    input wire latch_write,
    input wire [`PCS_HIGH_W-1:0] latch_wdata,
    input wire do_jump,
    input wire do_call,
    input wire [`PCS_JUMP_W-1:0] jump_target,
    input wire do_return,
    input wire int_vector,
    output reg [`PCS_PC_W-1:0] fetch_addr,
    output reg [`PCS_LOW_W-1:0] low_rdata,
    output reg [`PCS_HIGH_W-1:0] latch_rdata
);
    localparam [5:0] SRC_HOLD = 6'h01;
    localparam [5:0] SRC_STEP = 6'h02;
    localparam [5:0] SRC_LOW = 6'h04;
    localparam [5:0] SRC_BRANCH = 6'h08;
    localparam [5:0] SRC_RETURN = 6'h10;
    localparam [5:0] SRC_VECTOR = 6'h20;

    // the low byte and the upper bits are separate registers, as software sees them
    reg [`PCS_LOW_W-1:0] pc_low;
    reg [`PCS_HIGH_W-1:0] pc_high;
    reg [`PCS_HIGH_W-1:0] high_latch;
    reg [`PCS_PC_W-1:0] next_pc;
    reg [`PCS_HIGH_W-1:0] next_high_latch;
    reg [`PCS_PC_W-1:0] push_data;
    reg push;
    reg pop;
    wire [`PCS_PC_W-1:0] pc;
    wire [`PCS_PC_W-1:0] pc_inc;
    wire [`PCS_PC_W-1:0] branch_addr;
    wire [`PCS_PC_W-1:0] low_addr;
    wire [`PCS_PC_W-1:0] stack_top;
    wire [5:0] source;

    // one priority order for the counter mux and the stack controls alike
    function [5:0] pick_source;
        input vec;
        input ret;
        input brn;
        input low;
        input stp;
        begin
            if (vec) begin
                pick_source = SRC_VECTOR;
            end else if (ret) begin
                pick_source = SRC_RETURN;
            end else if (brn) begin
                pick_source = SRC_BRANCH;
            end else if (low) begin
                pick_source = SRC_LOW;
            end else if (stp) begin
                pick_source = SRC_STEP;
            end else begin
                pick_source = SRC_HOLD;
            end
        end
    endfunction

    assign pc = {pc_high, pc_low};
    assign pc_inc = pc + `PCS_PC_W'h0001;
    assign source = pick_source(int_vector, do_return, do_call | do_jump, low_write, step);
    // page from latch, offset from instruction; 8K space in 2K pages
    assign branch_addr = {high_latch[`PCS_PAGE_MSB:`PCS_PAGE_LSB], jump_target};
    // only the low byte comes from data; tables must not straddle 256 words
    assign low_addr = {high_latch, low_wdata};

    // a call that loses to a return or an interrupt must not leave a stale entry
    always @* begin
        push = 1'b0;
        pop = 1'b0;
        case (source)
            SRC_VECTOR: begin
                push = 1'b1;
            end
            SRC_RETURN: begin
                pop = 1'b1;
            end
            SRC_BRANCH: begin
                push = do_call;
            end
            default: begin
                push = 1'b0;
                pop = 1'b0;
            end
        endcase
    end

    // an interrupt saves the instruction it displaced, a call saves its successor
    always @* begin
        push_data = pc_inc;
        if (source == SRC_VECTOR) begin
            push_data = pc;
        end
    end

    pcs_return_stack #(
        .DEPTH(STACK_DEPTH),
        .PTR_W(STACK_PTR_W),
        .WIDTH(`PCS_PC_W)
    ) u_stack (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .push(push),
        .pop(pop),
        .push_data(push_data),
        .top_data(stack_top)
    );

    always @* begin
        next_pc = pc;
        case (source)
            SRC_VECTOR: begin
                next_pc = INT_VECTOR;
            end
            SRC_RETURN: begin
                next_pc = stack_top;
            end
            SRC_BRANCH: begin
                next_pc = branch_addr;
            end
            SRC_LOW: begin
                next_pc = low_addr;
            end
            SRC_STEP: begin
                next_pc = pc_inc;
            end
            SRC_HOLD: begin
                next_pc = pc;
            end
            default: begin
                next_pc = pc;
            end
        endcase
    end

    // stack traffic never touches the latch; only its own write moves it
    always @* begin
        next_high_latch = high_latch;
        if (latch_write) begin
            next_high_latch = latch_wdata;
        end
    end

    // low byte: the register software reads and writes
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_low <= `PCS_LOW_RESET;
        end else if (clk_en) begin
            pc_low <= next_pc[`PCS_LOW_W-1:0];
        end
    end

    // upper bits: no read path, loaded from the latch, the stack, the branch target or the vector, or stepped by carry
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_high <= `PCS_HIGH_RESET;
        end else if (clk_en) begin
            pc_high <= next_pc[`PCS_PC_W-1:`PCS_LOW_W];
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_latch <= `PCS_LATCH_RESET;
        end else if (clk_en) begin
            high_latch <= next_high_latch;
        end
    end

    // registered copies keep every port straight from a flop, at the price of a few flops
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr <= `PCS_PC_RESET;
        end else if (clk_en) begin
            fetch_addr <= next_pc;
        end
    end

    // only the low byte is visible; the upper bits have no read path
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_rdata <= `PCS_LOW_RESET;
        end else if (clk_en) begin
            low_rdata <= next_pc[`PCS_LOW_W-1:0];
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_rdata <= `PCS_LATCH_RESET;
        end else if (clk_en) begin
            latch_rdata <= next_high_latch;
        end
    end
endmodule // pcs_program_counter

//--- tb/pcs_decoder_model.sv
// decoder stand-in: op codes 1..7 each become one control pulse a cycle; op 0 gives none
`timescale 1ns/10ps
module pcs_decoder_model (input wire [2:0] op, input wire [12:0] arg, output wire step, low_write, latch_write,
    do_jump, do_call, do_return, int_vector, output wire [7:0] low_wdata, output wire [4:0] latch_wdata,
    output wire [10:0] jump_target);
    wire [7:0] hot = 8'h01 << op;
    // one pulse at a time, so the core's priority order is never exercised here
    assign {int_vector, do_return, do_call, do_jump, latch_write, low_write, step} = hot[7:1];
    assign low_wdata = arg[7:0];
    assign latch_wdata = arg[4:0];
    assign jump_target = arg[10:0];
endmodule // pcs_decoder_model

//--- tb/pcs_program_counter_monitor.sv
// port assertions for the program counter block
`timescale 1ns/10ps
module pcs_pc_monitor #(parameter [12:0] INT_VECTOR = 13'h0004) (input wire core_clk, rst_n, clk_en, step,
    low_write, latch_write, do_jump, do_call, do_return, int_vector, input wire [7:0] low_wdata, low_rdata,
    input wire [4:0] latch_wdata, latch_rdata, input wire [10:0] jump_target, input wire [12:0] fetch_addr);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire nb = clk_en && !int_vector && !do_return;
    branch_dest_a: assert property (nb && (do_jump || do_call) |=>
        fetch_addr == {$past(latch_rdata[4:3]), $past(jump_target)}) else $error("bad branch");
    low_load_a: assert property (nb && low_write && !do_jump && !do_call |=>
        fetch_addr == {$past(latch_rdata), $past(low_wdata)}) else $error("bad low write");
    pc_step_a: assert property (nb && step && !do_jump && !do_call && !low_write |=>
        fetch_addr == $past(fetch_addr) + 13'h0001) else $error("bad step");
    low_read_a: assert property (low_rdata == fetch_addr[7:0]) else $error("bad low read");
    latch_hold_a: assert property (!(clk_en && latch_write) |=> $stable(latch_rdata)) else $error("latch moved");
    latch_load_a: assert property (clk_en && latch_write |=> latch_rdata == $past(latch_wdata))
        else $error("bad latch");
    int_entry_a: assert property (clk_en && int_vector |=> fetch_addr == INT_VECTOR) else $error("bad vector");
    call_return_a: assert property (nb && do_call ##1 clk_en && do_return && !int_vector |=>
        fetch_addr == $past(fetch_addr, 2) + 13'h0001) else $error("bad return");
    freeze_hold_a: assert property (!clk_en |=> $stable(fetch_addr) && $stable(latch_rdata))
        else $error("moved while frozen");
endmodule // pcs_pc_monitor
bind pcs_program_counter pcs_pc_monitor #(.INT_VECTOR(INT_VECTOR)) mon (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .step(step), .low_write(low_write), .latch_write(latch_write), .do_jump(do_jump),
    .do_call(do_call), .do_return(do_return), .int_vector(int_vector), .low_wdata(low_wdata),
    .low_rdata(low_rdata), .latch_wdata(latch_wdata), .latch_rdata(latch_rdata), .jump_target(jump_target),
    .fetch_addr(fetch_addr));

//--- tb/testbench.sv
// self-checking bench for the program counter block
`timescale 1ns/10ps
module testbench;
    reg core_clk = 0, rst_n = 0, clk_en = 1;
    reg [2:0] op = 0;
    reg [12:0] arg = 0;
    wire step, low_write, latch_write, do_jump, do_call, do_return, int_vector;
    wire [7:0] low_wdata, low_rdata;
    wire [4:0] latch_wdata, latch_rdata;
    wire [10:0] jump_target;
    wire [12:0] fetch_addr;
    reg [12:0] val;
    integer failures = 0, tests_run = 0, cyc = 0, i, j;
    reg [28:0] rows [0:10];
    always #20 core_clk = ~core_clk;
    pcs_decoder_model model (.op(op), .arg(arg), .step(step), .low_write(low_write), .latch_write(latch_write),
        .do_jump(do_jump), .do_call(do_call), .do_return(do_return), .int_vector(int_vector),
        .low_wdata(low_wdata), .latch_wdata(latch_wdata), .jump_target(jump_target));
    pcs_program_counter dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .step(step),
        .low_write(low_write), .low_wdata(low_wdata), .latch_write(latch_write), .latch_wdata(latch_wdata),
        .do_jump(do_jump), .do_call(do_call), .jump_target(jump_target), .do_return(do_return),
        .int_vector(int_vector), .fetch_addr(fetch_addr), .low_rdata(low_rdata), .latch_rdata(latch_rdata));
    task go(input [2:0] o, input [12:0] a); begin
        op = o;
        arg = a;
        @(posedge core_clk);
        #1;
    end endtask
    task cmp(input [12:0] g, input [12:0] e); begin
        tests_run = tests_run + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("BAD %0t %h %h", $time, g, e);
        end
    end endtask
    task cmp_low(input [7:0] g, input [7:0] e); begin
        tests_run = tests_run + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("BAD %0t %h %h", $time, g, e);
        end
    end endtask
    task cmp_latch(input [4:0] g, input [4:0] e); begin
        tests_run = tests_run + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("BAD %0t %h %h", $time, g, e);
        end
    end endtask
    task results; begin
        $display("%0d compares, %0d failures", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    end endtask
    // the whole run needs under a hundred cycles
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 200) begin
            failures = failures + 1;
            results;
        end
    end
    initial begin
        // op codes: 1 step, 2 low write, 3 latch write, 4 jump, 5 call, 6 return, 7 interrupt
        rows[0] = {3'h3, 13'h0018, 13'h0000};
        rows[1] = {3'h2, 13'h00fe, 13'h18fe};
        rows[2] = {3'h1, 13'h0000, 13'h18ff};
        rows[3] = {3'h5, 13'h0123, 13'h1923};
        rows[4] = {3'h3, 13'h0008, 13'h1923};
        rows[5] = {3'h5, 13'h0005, 13'h0805};
        rows[6] = {3'h6, 13'h0000, 13'h1924};
        rows[7] = {3'h6, 13'h0000, 13'h1900};
        rows[8] = {3'h7, 13'h0000, 13'h0004};
        rows[9] = {3'h6, 13'h0000, 13'h1900};
        rows[10] = {3'h4, 13'h07ff, 13'h0fff};
        repeat (6) @(posedge core_clk);
        #1 rst_n = 1;
        for (i = 0; i < 11; i = i + 1) begin
            go(rows[i][28:26], rows[i][25:13]);
            cmp(fetch_addr, rows[i][12:0]);
            cmp_low(low_rdata, rows[i][7:0]);
        end
        cmp_latch(latch_rdata, 5'h08);
        $display("rows done");
        go(3'h3, 13'h0000);
        // nine calls into eight slots: the ninth lands on the first slot
        for (i = 0; i < 9; i = i + 1) begin
            val = {i[9:0], 3'h0};
            go(3'h5, val);
        end
        for (i = 0; i < 9; i = i + 1) begin
            go(3'h6, 13'h0000);
            j = 8 * ((15 - i) % 8) + 1;
            cmp(fetch_addr, j[12:0]);
        end
        $display("wrap done");
        // with the enable low neither the step nor the call may act
        clk_en = 0;
        go(3'h1, 13'h0000);
        go(3'h5, 13'h0100);
        cmp(fetch_addr, 13'h0039);
        clk_en = 1;
        go(3'h1, 13'h0000);
        cmp(fetch_addr, 13'h003a);
        go(3'h6, 13'h0000);
        cmp(fetch_addr, 13'h0031);
        go(3'h2, 13'h0036);
        cmp(fetch_addr, 13'h0036);
        $display("freeze done");
        go(3'h3, 13'h001f);
        go(3'h2, 13'h0000);
        cmp(fetch_addr, 13'h1f00);
        cmp_latch(latch_rdata, 5'h1f);
        op = 0;
        rst_n = 0;
        #5 cmp(fetch_addr, 13'h0000);
        cmp_latch(latch_rdata, 5'h00);
        cmp_low(low_rdata, 8'h00);
        @(posedge core_clk);
        #1 rst_n = 1;
        go(3'h1, 13'h0000);
        cmp(fetch_addr, 13'h0001);
        go(3'h2, 13'h0080);
        cmp(fetch_addr, 13'h0080);
        $display("reset done");
        results;
    end
endmodule // testbench
